// >>> srv_map.vh
// Constants of the stream read and read verify command block.
// Assumes an ATA style task file with eight register addresses and a 40 MHz system clock.
`ifndef SRV_MAP_VH
`define SRV_MAP_VH

// Task file register addresses.
`define SRV_TF_DATA 3'h0
`define SRV_TF_FEAT_ERR 3'h1
`define SRV_TF_COUNT 3'h2
`define SRV_TF_SECT 3'h3
`define SRV_TF_CYL_LO 3'h4
`define SRV_TF_CYL_HI 3'h5
`define SRV_TF_DEVHEAD 3'h6
`define SRV_TF_CMD_STAT 3'h7

// Command opcodes.
`define SRV_OP_READ_STREAM 8'h2b
`define SRV_OP_VERIFY 8'h40
`define SRV_OP_VERIFY_R 8'h41

// Current feature byte fields.
`define SRV_FEAT_URGENT 7
`define SRV_FEAT_CONT_READ 6
`define SRV_FEAT_NONSEQ 5
`define SRV_FEAT_RESUME 4
`define SRV_FEAT_STREAM_HI 2
`define SRV_FEAT_STREAM_LO 0

// Device/head fields.
`define SRV_DH_LBA_MODE 6
`define SRV_DH_HEAD_HI 3
`define SRV_DH_HEAD_LO 0

// Error register bit positions.
`define SRV_ERR_UNC 6
`define SRV_ERR_IDNF 4
`define SRV_ERR_ABRT 2
`define SRV_ERR_TIMEOUT 0

// Status register bit positions.
`define SRV_ST_BSY 7
`define SRV_ST_RDY 6
`define SRV_ST_SE 5
`define SRV_ST_DSC 4
`define SRV_ST_DRQ 3
`define SRV_ST_ERR 0

// Medium sector result codes.
`define SRV_MED_OK 2'h0
`define SRV_MED_UNC 2'h1
`define SRV_MED_IDNF 2'h2
`define SRV_MED_ABRT 2'h3

// Sector counts that a zero count stands for.
`define SRV_STREAM_ZERO_COUNT 17'h10000
`define SRV_VERIFY_ZERO_COUNT 17'h00100

// Timing: clock period and microsecond in ns, cycles per microsecond derived.
`define SRV_CLK_PERIOD_NS 25
`define SRV_US_NS 1000
`define SRV_CYC_PER_US (`SRV_US_NS / `SRV_CLK_PERIOD_NS)
// Least completion time limit in microseconds.
`define SRV_MIN_LIMIT_US 40'd100

// Reset values.
`define SRV_RST_BYTE 8'h00
`define SRV_RST_STATUS 8'h40

`endif

// >>> srv_cmd.v
// Stream read and read verify command interpreter with its data FIFO.
// Assumes a host that writes the task file through the byte port and a medium engine
// that reads sectors, reports each sector's result and pushes read data with back-pressure.
//
// Behaviour
// RULE_01 - Opcode 2Bh starts the streaming read command.
// RULE_02 - Feature bit 7 requests urgent completion within limit.
// RULE_03 - Continuous read never aborts on read errors.
// RULE_04 - Without continuous read, ordinary streaming read behaviour.
// RULE_05 - Continuous errors: full transfer, stream error, log.
// RULE_06 - Continuous timeout stops; stream error, timeout logged.
// RULE_07 - Always move whole amount within time limit.
// RULE_08 - Host may flag next read non-sequential.
// RULE_09 - Feature bit 4 resumes stream error recovery.
// RULE_10 - Feature bits 2..0 select the stream.
// RULE_11 - Limit is previous feature times identify unit.
// RULE_12 - Zero byte uses stream default; zero disables.
// RULE_13 - Limit counted from command write to completion.
// RULE_14 - Limits below minimum are raised to minimum.
// RULE_15 - Sixteen bit stream count, zero means 65536.
// RULE_16 - 48-bit address split over current/previous bytes.
// RULE_17 - Error address returned, high bytes by select.
// RULE_18 - Error bit 0 flags an exceeded limit.
// RULE_19 - Stream error gives first address, suspect count.
// RULE_20 - Continuous errors go to log, error clear.
// RULE_21 - Opcodes 40h/41h verify without moving data.
// RULE_22 - Verify stops at the uncorrectable sector.
// RULE_23 - Verify count eight bits, zero means 256.
// RULE_24 - Verify address is 28-bit LBA or CHS.
// RULE_25 - Verify returns residual count and last sector.
// RULE_26 - Verify error clears busy, sets error and cause.
`timescale 1ns/1ps
`include "srv_map.vh"

////////////////////////////////////////////////////////////////////////////////
// Synchronous FIFO with registered flags; flush empties it in one cycle.
module srv_fifo #(
	parameter W = 16,
	parameter D = 8,
	parameter AW = 3
) (
	input wire clk,
	input wire rst,
	input wire flush,
	input wire [W-1:0] in_data,
	input wire in_valid,
	output reg in_ready,
	output wire [W-1:0] out_data,
	output reg out_valid,
	input wire out_ready
);
	reg [W-1:0] mem [0:D-1]; // Storage words.
	reg [AW-1:0] wp_r; // Write index.
	reg [AW-1:0] rp_r; // Read index.
	reg [AW:0] cnt_r; // Words held.
	wire push = in_valid & in_ready;
	wire pop = out_valid & out_ready;
	wire [AW:0] cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

	// The head word is read straight from the flip-flop array.
	assign out_data = mem[rp_r];

	// Pointers, count and flags; flags are registered so neither side sees a combinational path.
	always @(posedge clk) begin
		if (rst || flush) begin
			wp_r <= {AW{1'b0}};
			rp_r <= {AW{1'b0}};
			cnt_r <= {(AW+1){1'b0}};
			in_ready <= 1'b1;
			out_valid <= 1'b0;
		end else begin
			if (push) begin
				wp_r <= (wp_r == D - 1) ? {AW{1'b0}} : wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= (rp_r == D - 1) ? {AW{1'b0}} : rp_r + 1'b1;
			end
			cnt_r <= cnt_nxt;
			in_ready <= (cnt_nxt != D);
			out_valid <= (cnt_nxt != 0);
		end
	end

	// Data storage has no reset; only written words are ever read.
	always @(posedge clk) begin
		if (push) begin
			mem[wp_r] <= in_data;
		end
	end
endmodule // srv_fifo

////////////////////////////////////////////////////////////////////////////////
// Command interpreter top.
module srv_cmd_top (
	input wire CLK_SYS,
	input wire RESET,
	input wire [2:0] TF_ADDR,
	input wire TF_WR,
	input wire [7:0] TF_WDATA,
	input wire TF_RD,
	output reg [7:0] TF_RDATA,
	input wire HIGH_BYTE_READ_SELECT,
	input wire [31:0] IDENT_TIME_UNIT,
	input wire CFG_WR,
	input wire [2:0] CFG_STREAM,
	input wire [7:0] CFG_DEFAULT_LIMIT,
	output reg MED_START,
	output reg MED_STOP,
	output reg [47:0] MED_ADDR,
	output reg [16:0] MED_COUNT,
	output reg MED_CHS,
	output reg MED_XFER,
	output reg MED_URGENT,
	output reg MED_TOLERANT,
	output reg MED_NONSEQ,
	output reg MED_RESUME,
	output reg [2:0] MED_STREAM,
	input wire MED_SECT_DONE,
	input wire [47:0] MED_SECT_ADDR,
	input wire [1:0] MED_SECT_ERR,
	input wire [15:0] MED_DATA,
	input wire MED_DVALID,
	output wire MED_DREADY,
	output wire [15:0] XFER_DATA,
	output wire XFER_VALID,
	input wire XFER_READY,
	output reg CMD_DONE,
	output reg [7:0] ERRLOG_BITS
);
	localparam ST_IDLE = 2'd0;
	localparam ST_RUN = 2'd1;
	localparam ST_DRAIN = 2'd2;
	localparam ST_END = 2'd3;
	localparam integer US_LAST_INT = `SRV_CYC_PER_US - 1; // Last divider count, full width.
	localparam [5:0] US_LAST = US_LAST_INT[5:0]; // Cut to the divider's width on purpose.

	// Maps a medium result code onto its error register bit.
	function [7:0] err_mask;
		input [1:0] code;
		begin
			case (code)
				`SRV_MED_UNC: err_mask = 8'h01 << `SRV_ERR_UNC;
				`SRV_MED_IDNF: err_mask = 8'h01 << `SRV_ERR_IDNF;
				`SRV_MED_ABRT: err_mask = 8'h01 << `SRV_ERR_ABRT;
				default: err_mask = 8'h00;
			endcase
		end
	endfunction

	// Task file registers: current and previous bytes of each two-deep register.
	reg [7:0] feat_cur_r, feat_prv_r, cnt_cur_r, cnt_prv_r;
	reg [7:0] sn_cur_r, sn_prv_r, cl_cur_r, cl_prv_r, ch_cur_r, ch_prv_r;
	reg [7:0] devhead_r; // Device/head register.
	reg [7:0] err_r; // Error register contents shown to the host.
	reg err_st_r; // Status error bit.
	reg se_r; // Stream error status bit.
	reg [1:0] state_r; // Command sequencer state.
	reg is_stream_r; // Running command is the streaming read.
	reg rc_r; // Continuous read latched at command write.
	reg [16:0] remain_r; // Sectors still to be processed.
	reg [47:0] last_addr_r; // Last sector the medium finished.
	reg [47:0] fail_addr_r; // First failing sector.
	reg [15:0] suspect_r; // Consecutive suspect sectors from the first failure.
	reg fail_seen_r; // A failure has been recorded for this command.
	reg run_open_r; // The suspect run is still unbroken.
	reg timeout_r; // Limit expired during this command.
	reg [7:0] dflt_r [0:7]; // Per-stream default limit bytes.
	reg lim_en_r; // A limit is enforced.
	reg [39:0] limit_r; // Limit in microseconds.
	reg [39:0] elapsed_r; // Microseconds since the command write.
	reg [5:0] us_div_r; // Divider producing a one microsecond enable.
	reg fifo_flush_r; // Drops buffered data on a new command or an abort.
	wire fifo_valid;
	wire fifo_in_ready;
	integer i;

	////////////////////////////////////////////////////////////////////////
	// Read data path: the medium fills the FIFO and stalls while it is full.
	srv_fifo #(.W(16), .D(8), .AW(3)) u_fifo (
		.clk(CLK_SYS),
		.rst(RESET),
		.flush(fifo_flush_r),
		.in_data(MED_DATA),
		.in_valid(MED_DVALID),
		.in_ready(fifo_in_ready),
		.out_data(XFER_DATA),
		.out_valid(fifo_valid),
		.out_ready(XFER_READY)
	);
	assign MED_DREADY = fifo_in_ready;
	assign XFER_VALID = fifo_valid;

	////////////////////////////////////////////////////////////////////////
	// Limit selection for a streaming read, decided from the bytes already written.
	reg [7:0] sel_byte; // Byte in force after the default lookup.
	reg [39:0] prod_us; // Byte times unit, before clamping.
	reg [39:0] lim_nxt; // Clamped limit.
	always @* begin
		sel_byte = (feat_prv_r != 8'h00) ? feat_prv_r :
			dflt_r[feat_cur_r[`SRV_FEAT_STREAM_HI:`SRV_FEAT_STREAM_LO]]; // RULE_12
		prod_us = {32'h0, sel_byte} * {8'h00, IDENT_TIME_UNIT}; // RULE_11
		lim_nxt = (prod_us < `SRV_MIN_LIMIT_US) ? `SRV_MIN_LIMIT_US : prod_us; // RULE_14
	end

	wire is_busy = (state_r != ST_IDLE);
	wire cmd_wr = TF_WR && !is_busy && (TF_ADDR == `SRV_TF_CMD_STAT);
	wire op_stream = (TF_WDATA == `SRV_OP_READ_STREAM); // RULE_01
	wire op_verify = (TF_WDATA == `SRV_OP_VERIFY) || (TF_WDATA == `SRV_OP_VERIFY_R); // RULE_21
	wire expired = lim_en_r && (elapsed_r >= limit_r);
	wire sect_bad = MED_SECT_DONE && (MED_SECT_ERR != `SRV_MED_OK);
	wire [16:0] stream_cnt = ({cnt_prv_r, cnt_cur_r} == 16'h0000) ?
		`SRV_STREAM_ZERO_COUNT : {1'b0, cnt_prv_r, cnt_cur_r}; // RULE_15
	wire [16:0] verify_cnt = (cnt_cur_r == 8'h00) ?
		`SRV_VERIFY_ZERO_COUNT : {9'h000, cnt_cur_r}; // RULE_23

	////////////////////////////////////////////////////////////////////////
	// Stream default limits; configuration may arrive at any time.
	always @(posedge CLK_SYS) begin
		if (RESET) begin
			for (i = 0; i < 8; i = i + 1) begin
				dflt_r[i] <= `SRV_RST_BYTE;
			end
		end else if (CFG_WR) begin
			dflt_r[CFG_STREAM] <= CFG_DEFAULT_LIMIT;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Elapsed time counted in whole microseconds from the command write.
	always @(posedge CLK_SYS) begin
		if (RESET || cmd_wr) begin
			us_div_r <= 6'h00; // RULE_13
			elapsed_r <= 40'h0;
		end else if (is_busy) begin
			if (us_div_r == US_LAST) begin
				us_div_r <= 6'h00;
				elapsed_r <= elapsed_r + 40'h1;
			end else begin
				us_div_r <= us_div_r + 6'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Host reads: the high-byte select picks previous bytes of the address and count.
	always @(posedge CLK_SYS) begin
		if (RESET) begin
			TF_RDATA <= `SRV_RST_BYTE;
		end else if (TF_RD) begin
			case (TF_ADDR)
				`SRV_TF_FEAT_ERR: TF_RDATA <= err_r;
				`SRV_TF_COUNT: TF_RDATA <= HIGH_BYTE_READ_SELECT ? cnt_prv_r : cnt_cur_r;
				`SRV_TF_SECT: TF_RDATA <= HIGH_BYTE_READ_SELECT ? sn_prv_r : sn_cur_r; // RULE_17
				`SRV_TF_CYL_LO: TF_RDATA <= HIGH_BYTE_READ_SELECT ? cl_prv_r : cl_cur_r;
				`SRV_TF_CYL_HI: TF_RDATA <= HIGH_BYTE_READ_SELECT ? ch_prv_r : ch_cur_r;
				`SRV_TF_DEVHEAD: TF_RDATA <= devhead_r;
				`SRV_TF_CMD_STAT: begin
					// Status: stream commands show the stream error bit, verify shows seek done.
					TF_RDATA <= {is_busy, 1'b1, is_stream_r & se_r, ~is_stream_r,
						is_busy & is_stream_r & fifo_valid, 2'b00, err_st_r};
				end
				default: TF_RDATA <= 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Command sequencer, task file writes and result write-back.
	always @(posedge CLK_SYS) begin
		if (RESET) begin
			state_r <= ST_IDLE;
			feat_cur_r <= `SRV_RST_BYTE;
			feat_prv_r <= `SRV_RST_BYTE;
			cnt_cur_r <= `SRV_RST_BYTE;
			cnt_prv_r <= `SRV_RST_BYTE;
			sn_cur_r <= `SRV_RST_BYTE;
			sn_prv_r <= `SRV_RST_BYTE;
			cl_cur_r <= `SRV_RST_BYTE;
			cl_prv_r <= `SRV_RST_BYTE;
			ch_cur_r <= `SRV_RST_BYTE;
			ch_prv_r <= `SRV_RST_BYTE;
			devhead_r <= `SRV_RST_BYTE;
			err_r <= `SRV_RST_BYTE;
			err_st_r <= 1'b0;
			se_r <= 1'b0;
			is_stream_r <= 1'b0;
			rc_r <= 1'b0;
			remain_r <= 17'h0;
			last_addr_r <= 48'h0;
			fail_addr_r <= 48'h0;
			suspect_r <= 16'h0;
			fail_seen_r <= 1'b0;
			run_open_r <= 1'b0;
			timeout_r <= 1'b0;
			lim_en_r <= 1'b0;
			limit_r <= 40'h0;
			fifo_flush_r <= 1'b0;
			MED_START <= 1'b0;
			MED_STOP <= 1'b0;
			MED_ADDR <= 48'h0;
			MED_COUNT <= 17'h0;
			MED_CHS <= 1'b0;
			MED_XFER <= 1'b0;
			MED_URGENT <= 1'b0;
			MED_TOLERANT <= 1'b0;
			MED_NONSEQ <= 1'b0;
			MED_RESUME <= 1'b0;
			MED_STREAM <= 3'h0;
			CMD_DONE <= 1'b0;
			ERRLOG_BITS <= `SRV_RST_BYTE;
		end else begin
			MED_START <= 1'b0;
			MED_STOP <= 1'b0;
			CMD_DONE <= 1'b0;
			fifo_flush_r <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					// Parameter writes to the two-deep registers shift the current byte into the previous one; device/head is overwritten.
					if (TF_WR) begin
						case (TF_ADDR)
							`SRV_TF_FEAT_ERR: begin
								feat_prv_r <= feat_cur_r;
								feat_cur_r <= TF_WDATA;
							end
							`SRV_TF_COUNT: begin
								cnt_prv_r <= cnt_cur_r;
								cnt_cur_r <= TF_WDATA;
							end
							`SRV_TF_SECT: begin
								sn_prv_r <= sn_cur_r;
								sn_cur_r <= TF_WDATA;
							end
							`SRV_TF_CYL_LO: begin
								cl_prv_r <= cl_cur_r;
								cl_cur_r <= TF_WDATA;
							end
							`SRV_TF_CYL_HI: begin
								ch_prv_r <= ch_cur_r;
								ch_cur_r <= TF_WDATA;
							end
							`SRV_TF_DEVHEAD: devhead_r <= TF_WDATA;
							default: ;
						endcase
					end
					if (cmd_wr) begin
						err_r <= 8'h00;
						err_st_r <= 1'b0;
						se_r <= 1'b0;
						fail_seen_r <= 1'b0;
						run_open_r <= 1'b0;
						suspect_r <= 16'h0;
						timeout_r <= 1'b0;
						fifo_flush_r <= 1'b1;
						is_stream_r <= op_stream;
						if (op_stream) begin
							// Stream parameters go straight to the medium engine.
							rc_r <= feat_cur_r[`SRV_FEAT_CONT_READ]; // RULE_03
							ERRLOG_BITS <= 8'h00;
							lim_en_r <= (sel_byte != 8'h00); // RULE_12
							limit_r <= lim_nxt;
							remain_r <= stream_cnt;
							MED_COUNT <= stream_cnt; // RULE_07
							MED_ADDR <= {ch_prv_r, cl_prv_r, sn_prv_r,
								ch_cur_r, cl_cur_r, sn_cur_r}; // RULE_16
							MED_CHS <= 1'b0;
							MED_XFER <= 1'b1;
							MED_URGENT <= feat_cur_r[`SRV_FEAT_URGENT]; // RULE_02
							MED_TOLERANT <= feat_cur_r[`SRV_FEAT_CONT_READ]; // RULE_04
							MED_NONSEQ <= feat_cur_r[`SRV_FEAT_NONSEQ]; // RULE_08
							MED_RESUME <= feat_cur_r[`SRV_FEAT_RESUME]; // RULE_09
							MED_STREAM <= feat_cur_r[`SRV_FEAT_STREAM_HI:`SRV_FEAT_STREAM_LO]; // RULE_10
							MED_START <= 1'b1;
							state_r <= ST_RUN;
						end else if (op_verify) begin
							rc_r <= 1'b0;
							lim_en_r <= 1'b0;
							remain_r <= verify_cnt;
							MED_COUNT <= verify_cnt;
							// LBA or packed head/cylinder/sector, by the addressing bit.
							MED_ADDR <= {20'h0, devhead_r[`SRV_DH_HEAD_HI:`SRV_DH_HEAD_LO],
								ch_cur_r, cl_cur_r, sn_cur_r}; // RULE_24
							MED_CHS <= ~devhead_r[`SRV_DH_LBA_MODE];
							MED_XFER <= 1'b0; // RULE_21
							MED_URGENT <= 1'b0;
							MED_TOLERANT <= 1'b0;
							MED_NONSEQ <= 1'b0;
							MED_RESUME <= 1'b0;
							MED_START <= 1'b1;
							state_r <= ST_RUN;
						end else begin
							// Unknown opcodes are refused at once with an abort.
							err_r <= 8'h01 << `SRV_ERR_ABRT;
							err_st_r <= 1'b1;
							CMD_DONE <= 1'b1;
						end
					end
				end
				ST_RUN: begin
					if (expired) begin
						// The limit ends the command in either mode.
						timeout_r <= 1'b1;
						MED_STOP <= 1'b1;
						fifo_flush_r <= 1'b1;
						state_r <= ST_END; // RULE_06
					end else if (MED_SECT_DONE) begin
						last_addr_r <= MED_SECT_ADDR;
						if (sect_bad) begin
							if (!fail_seen_r) begin
								fail_seen_r <= 1'b1;
								fail_addr_r <= MED_SECT_ADDR;
								suspect_r <= 16'h1;
								run_open_r <= 1'b1;
							end else if (run_open_r) begin
								suspect_r <= suspect_r + 16'h1; // RULE_19
							end
							if (rc_r) begin
								// Continuous mode logs the cause and keeps going.
								ERRLOG_BITS <= ERRLOG_BITS | err_mask(MED_SECT_ERR); // RULE_20
								remain_r <= remain_r - 17'h1;
								if (remain_r == 17'h1) begin
									state_r <= ST_DRAIN; // RULE_05
								end
							end else begin
								// Otherwise the failing sector ends the command.
								err_r <= err_mask(MED_SECT_ERR);
								MED_STOP <= 1'b1;
								if (is_stream_r) begin
									fifo_flush_r <= 1'b1;
								end
								state_r <= ST_END; // RULE_22
							end
						end else begin
							run_open_r <= 1'b0;
							remain_r <= remain_r - 17'h1;
							if (remain_r == 17'h1) begin
								state_r <= is_stream_r ? ST_DRAIN : ST_END;
							end
						end
					end
				end
				ST_DRAIN: begin
					// Completion waits until the host has taken every buffered word or the limit expires.
					if (expired) begin
						timeout_r <= 1'b1;
						fifo_flush_r <= 1'b1;
						state_r <= ST_END; // RULE_13
					end else if (!fifo_valid) begin
						state_r <= ST_END;
					end
				end
				ST_END: begin
					CMD_DONE <= 1'b1;
					state_r <= ST_IDLE;
					if (is_stream_r) begin
						if (rc_r && (fail_seen_r || timeout_r)) begin
							se_r <= 1'b1; // RULE_05
							err_st_r <= 1'b0; // RULE_20
							err_r <= 8'h00;
							if (timeout_r) begin
								ERRLOG_BITS[`SRV_ERR_TIMEOUT] <= 1'b1; // RULE_06
							end
						end else if (timeout_r || fail_seen_r) begin
							err_st_r <= 1'b1;
							if (timeout_r) begin
								err_r[`SRV_ERR_TIMEOUT] <= 1'b1; // RULE_18
							end
						end
						if (fail_seen_r) begin
							// First failing sector goes back into the address bytes.
							{ch_prv_r, cl_prv_r, sn_prv_r} <= fail_addr_r[47:24]; // RULE_17
							{ch_cur_r, cl_cur_r, sn_cur_r} <= fail_addr_r[23:0];
							if (rc_r) begin
								{cnt_prv_r, cnt_cur_r} <= suspect_r; // RULE_19
							end
						end
					end else begin
						// Verify: residual count and the last sector processed.
						cnt_cur_r <= remain_r[7:0]; // RULE_25
						{ch_cur_r, cl_cur_r, sn_cur_r} <= last_addr_r[23:0];
						devhead_r[`SRV_DH_HEAD_HI:`SRV_DH_HEAD_LO] <= last_addr_r[27:24];
						err_st_r <= fail_seen_r; // RULE_26
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end
endmodule // srv_cmd_top

// >>> srv_cmd_monitor.sv
// Checker for the stream read and verify command block.
// Sees only top-level ports; one clock, synchronous active-high reset.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module srv_cmd_monitor (
	input logic CLK_SYS,
	input logic RESET,
	input logic [2:0] TF_ADDR,
	input logic TF_WR,
	input logic [7:0] TF_WDATA,
	input logic TF_RD,
	input logic [7:0] TF_RDATA,
	input logic MED_START,
	input logic MED_STOP,
	input logic [16:0] MED_COUNT,
	input logic MED_XFER,
	input logic MED_TOLERANT,
	input logic MED_SECT_DONE,
	input logic [1:0] MED_SECT_ERR,
	input logic XFER_VALID,
	input logic CMD_DONE,
	input logic [7:0] ERRLOG_BITS
);
	// High from a command write until its completion pulse.
	logic busy_r;
	wire cmd_wr = TF_WR && TF_ADDR == 3'h7;
	wire known = TF_WDATA == 8'h2b || TF_WDATA == 8'h40 || TF_WDATA == 8'h41;
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RESET);
	// Tracks the command in flight, so sector pulses are judged only while busy.
	always @(posedge CLK_SYS) begin
		if (RESET)
			busy_r <= 1'b0;
		else if (CMD_DONE)
			busy_r <= 1'b0;
		else if (cmd_wr)
			busy_r <= 1'b1;
	end
	sequence s_good_cmd;
		cmd_wr && !busy_r && known;
	endsequence
	sequence s_hard_err;
		busy_r && MED_SECT_DONE && MED_SECT_ERR != 2'h0 && !MED_TOLERANT;
	endsequence
	sequence s_stop_done;
		MED_STOP ##1 CMD_DONE;
	endsequence
	AST_START: assert property (s_good_cmd |=> MED_START && MED_XFER == ($past(TF_WDATA) == 8'h2b))
		else $error("command did not start the medium");
	AST_REFUSE: assert property (cmd_wr && !busy_r && !known |=> !MED_START ##[0:1] CMD_DONE)
		else $error("unknown opcode not refused");
	AST_HARD_STOP: assert property (s_hard_err |=> s_stop_done)
		else $error("error did not stop the command");
	AST_NO_ABORT: assert property (busy_r && MED_SECT_DONE && MED_SECT_ERR != 2'h0 && MED_TOLERANT
		|=> !MED_STOP && !CMD_DONE)
		else $error("continuous read aborted on error");
	AST_NO_DATA: assert property (!MED_XFER && !MED_START |-> !XFER_VALID)
		else $error("verify moved data");
	AST_COUNT: assert property (MED_START |-> MED_COUNT != 17'h0
		&& MED_COUNT <= (MED_XFER ? 17'h10000 : 17'h00100))
		else $error("sector count out of range");
	AST_LOG_CLR: assert property (MED_START && MED_XFER |=> ERRLOG_BITS == 8'h00)
		else $error("error log not cleared at start");
	AST_DONE_PULSE: assert property (CMD_DONE |=> !CMD_DONE && !MED_START)
		else $error("completion pulse too long");
	AST_RD_HOLD: assert property (!TF_RD |=> $stable(TF_RDATA))
		else $error("read data changed without a read");
endmodule // srv_cmd_monitor

bind srv_cmd_top srv_cmd_monitor i_srv_cmd_monitor (.CLK_SYS(CLK_SYS), .RESET(RESET),
	.TF_ADDR(TF_ADDR), .TF_WR(TF_WR), .TF_WDATA(TF_WDATA), .TF_RD(TF_RD), .TF_RDATA(TF_RDATA),
	.MED_START(MED_START), .MED_STOP(MED_STOP), .MED_COUNT(MED_COUNT), .MED_XFER(MED_XFER),
	.MED_TOLERANT(MED_TOLERANT), .MED_SECT_DONE(MED_SECT_DONE), .MED_SECT_ERR(MED_SECT_ERR),
	.XFER_VALID(XFER_VALID), .CMD_DONE(CMD_DONE), .ERRLOG_BITS(ERRLOG_BITS));

// >>> srv_medium_model.sv
// Behavioural medium engine: sector results and read data for the block.
// Assumes the block's start, stop and parameter outputs hold per the hand-over.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module srv_medium_model (
	input logic clk,
	input logic rst,
	input logic med_start,
	input logic med_stop,
	input logic [47:0] med_addr,
	input logic [16:0] med_count,
	input logic med_xfer,
	input int gap,
	input logic [16:0] err_idx,
	input logic [1:0] err_code,
	output logic sect_done,
	output logic [47:0] sect_addr,
	output logic [1:0] sect_err,
	output logic [15:0] data,
	output logic dvalid,
	input logic dready
);
	// Set once the block asks to abort; no sector follows it.
	logic stopped;
	// One clock edge; a stop seen there ends the job.
	task automatic tick();
		@(posedge clk);
		if (med_stop)
			stopped = 1'b1;
	endtask
	// Walks sectors from the start address; released lines show inverted values.
	initial begin
		{sect_done, dvalid, stopped} = 3'h0;
		{sect_addr, sect_err, data} = '0;
		forever begin
			@(posedge clk);
			if (med_start && !rst) begin
				stopped = 1'b0;
				for (int i = 0; i < med_count && !stopped; i++) begin
					for (int j = 0; j < gap && !stopped; j++)
						tick();
					if (med_xfer && !stopped) begin
						data <= i[15:0];
						dvalid <= 1'b1;
						do tick(); while (!dready);
						dvalid <= 1'b0;
						data <= ~i[15:0];
					end
					if (!stopped) begin
						sect_done <= 1'b1;
						sect_addr <= med_addr + 48'(i);
						sect_err <= (i == err_idx) ? err_code : 2'h0;
						tick();
						sect_done <= 1'b0;
						sect_addr <= ~sect_addr;
						sect_err <= ~sect_err;
					end
				end
			end
		end
	end
endmodule // srv_medium_model

// >>> srv_cmd_top_bench.sv
// Self-checking bench for the stream read and verify command block.
// Assumes the medium model file and the checker bind are compiled beforehand.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module srv_cmd_top_bench;
	logic CLK_SYS = 0, RESET = 1, TF_WR = 0, TF_RD = 0, HIGH_BYTE_READ_SELECT = 0;
	logic CFG_WR = 0, XFER_READY = 0;
	logic [2:0] TF_ADDR = 0, CFG_STREAM = 0;
	logic [7:0] TF_WDATA = 0, CFG_DEFAULT_LIMIT = 0, TF_RDATA, ERRLOG_BITS;
	logic [31:0] IDENT_TIME_UNIT = 0;
	logic MED_START, MED_STOP, MED_CHS, MED_XFER, MED_URGENT, MED_TOLERANT, MED_NONSEQ;
	logic MED_RESUME, MED_SECT_DONE, MED_DVALID, MED_DREADY, XFER_VALID, CMD_DONE;
	logic [47:0] MED_ADDR, MED_SECT_ADDR;
	logic [16:0] MED_COUNT;
	logic [2:0] MED_STREAM;
	logic [1:0] MED_SECT_ERR;
	logic [15:0] MED_DATA, XFER_DATA, word_cnt;
	int n_fail = 0, n_tests = 0, m_gap = 2;
	logic [16:0] m_err_idx = 17'h1ffff;
	logic [1:0] m_err_code = 2'h0;
	srv_cmd_top i_srv_cmd_top (.*);
	srv_medium_model i_srv_medium_model (.clk(CLK_SYS), .rst(RESET), .med_start(MED_START),
		.med_stop(MED_STOP), .med_addr(MED_ADDR), .med_count(MED_COUNT), .med_xfer(MED_XFER),
		.gap(m_gap), .err_idx(m_err_idx), .err_code(m_err_code), .sect_done(MED_SECT_DONE),
		.sect_addr(MED_SECT_ADDR), .sect_err(MED_SECT_ERR), .data(MED_DATA),
		.dvalid(MED_DVALID), .dready(MED_DREADY));
	always #12.5 CLK_SYS = ~CLK_SYS;
	// Host stalls every other cycle so the FIFO feels back-pressure.
	always @(posedge CLK_SYS) begin
		XFER_READY <= ~XFER_READY;
		if (MED_START)
			word_cnt <= 16'h0;
		else if (XFER_VALID && XFER_READY) begin
			chk(XFER_DATA, word_cnt);
			word_cnt <= word_cnt + 16'h1;
		end
	end
	task automatic conclude();
		if (n_fail == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			n_fail++;
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge CLK_SYS);
		TF_ADDR <= a;
		TF_WDATA <= d;
		TF_WR <= 1'b1;
		@(posedge CLK_SYS);
		TF_WR <= 1'b0;
	endtask
	task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
		@(posedge CLK_SYS);
		TF_ADDR <= a;
		TF_RD <= 1'b1;
		@(posedge CLK_SYS);
		TF_RD <= 1'b0;
		@(posedge CLK_SYS) chk(TF_RDATA, exp);
	endtask
	// Bounded wait for the completion pulse; returns cycles since the command.
	task automatic wait_done(output int cyc);
		cyc = 0;
		do begin
			@(posedge CLK_SYS);
			cyc++;
			if (cyc > 20000) begin
				n_fail++;
				conclude();
			end
		end while (CMD_DONE !== 1'b1);
	endtask
	// Previous byte first, then current, for the three address registers.
	task automatic run_stream(input logic [7:0] fp, fc, input logic [15:0] cnt, output int c);
		logic [7:0] lb [6] = '{8'hab, 8'h10, 8'hcd, 8'h20, 8'hef, 8'h30};
		wr(3'h1, fp);
		wr(3'h1, fc);
		wr(3'h2, cnt[15:8]);
		wr(3'h2, cnt[7:0]);
		for (int i = 0; i < 6; i++)
			wr(3'(3 + i / 2), lb[i]);
		wr(3'h6, 8'h40);
		wr(3'h7, 8'h2b);
		wait_done(c);
		chk(MED_ADDR, 48'hefcdab302010);
	endtask
	task automatic run_verify(input logic [7:0] op, dh, cnt, output int c);
		wr(3'h2, cnt);
		wr(3'h3, 8'h56);
		wr(3'h4, 8'h34);
		wr(3'h5, 8'h12);
		wr(3'h6, dh);
		wr(3'h7, op);
		wait_done(c);
	endtask
	task automatic t_verify();
		int c;
		run_verify(8'h40, 8'h45, 8'h03, c);
		chk(MED_ADDR, 48'h5123456);
		chk({MED_CHS, MED_XFER, MED_COUNT}, 19'h3);
		rd_chk(3'h7, 8'h50);
		rd_chk(3'h2, 8'h00);
		rd_chk(3'h3, 8'h58);
		m_err_idx = 17'h1;
		m_err_code = 2'h1;
		run_verify(8'h41, 8'ha3, 8'h00, c);
		chk({MED_CHS, MED_COUNT}, 18'h20100);
		chk(MED_ADDR, 48'h3123456);
		rd_chk(3'h7, 8'h51);
		rd_chk(3'h1, 8'h40);
		rd_chk(3'h2, 8'hff);
		rd_chk(3'h3, 8'h57);
	endtask
	task automatic t_stream();
		int c;
		m_err_idx = 17'h1ffff;
		run_stream(8'h00, 8'h83, 16'h0004, c);
		chk({MED_URGENT, MED_TOLERANT, MED_STREAM, MED_COUNT}, 22'h260004);
		chk(word_cnt, 16'h4);
		rd_chk(3'h7, 8'h40);
		m_err_idx = 17'h0;
		m_err_code = 2'h2;
		run_stream(8'h00, 8'h71, 16'h0002, c);
		chk({MED_TOLERANT, MED_NONSEQ, MED_RESUME, MED_STREAM}, 6'h39);
		chk(word_cnt, 16'h2);
		chk(ERRLOG_BITS, 8'h10);
		rd_chk(3'h7, 8'h60);
		rd_chk(3'h1, 8'h00);
		rd_chk(3'h3, 8'h10);
		rd_chk(3'h2, 8'h01);
		HIGH_BYTE_READ_SELECT <= 1'b1;
		rd_chk(3'h3, 8'hab);
		rd_chk(3'h5, 8'hef);
		HIGH_BYTE_READ_SELECT <= 1'b0;
	endtask
	task automatic t_limit();
		int c;
		m_err_idx = 17'h1ffff;
		m_gap = 30000;
		IDENT_TIME_UNIT <= 32'h1;
		run_stream(8'h01, 8'h40, 16'h0004, c);
		chk(c >= 3990 && c <= 4020, 1'b1);
		chk(ERRLOG_BITS, 8'h01);
		rd_chk(3'h7, 8'h60);
		@(posedge CLK_SYS);
		CFG_STREAM <= 3'h2;
		CFG_DEFAULT_LIMIT <= 8'h02;
		CFG_WR <= 1'b1;
		IDENT_TIME_UNIT <= 32'd100;
		@(posedge CLK_SYS);
		CFG_WR <= 1'b0;
		run_stream(8'h00, 8'h02, 16'h0004, c);
		chk(c >= 7990 && c <= 8020, 1'b1);
		rd_chk(3'h1, 8'h01);
		rd_chk(3'h7, 8'h41);
		wr(3'h7, 8'hee);
		wait_done(c);
		rd_chk(3'h1, 8'h04);
	endtask
	initial begin
		repeat (8) @(posedge CLK_SYS);
		RESET <= 1'b0;
		rd_chk(3'h7, 8'h50);
		t_verify();
		t_stream();
		t_limit();
		conclude();
	end
endmodule // srv_cmd_top_bench
